// *** src/ctts_supervisor.sv ***
// charge thermal and safety timer supervisor with register port
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps

module ctts_supervisor
    import ctts_pkg::*;
#(
    parameter int unsigned SEC_CYCLES   = SEC_CYC,
    parameter int unsigned PULSE_CYCLES = IRQ_PULSE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic      [31:0] rdata_o,
    // comparator and analog status inputs
    input  wire ctts_ts_t    ts_cmp_i,
    input  wire logic        charge_enable_pin_n_i,
    input  wire logic        charge_request_i,
    input  wire logic        restart_i,
    input  wire logic        fault_suspend_i,
    input  wire logic        batt_above_low_i,
    input  wire logic        iin_limit_i,
    input  wire logic        vin_limit_i,
    input  wire logic        thermal_reg_i,
    input  wire logic        sys_at_min_i,
    input  wire logic        boost_request_i,
    input  wire logic [2:0]  bus_source_i,
    input  wire logic        supplement_req_i,
    input  wire logic        batt_depleted_i,
    // controls to the regulation loops
    output logic             charging_o,
    output logic [1:0]       current_select_o,
    output logic             voltage_limit_4v1_o,
    output logic             dpm_reduce_o,
    output logic             boost_enable_o,
    output logic             battery_switch_on_o,
    output logic             supplement_o,
    output logic [2:0]       min_system_voltage_setting_o,
    output logic             interrupt_pulse_n_o
);

    localparam int PW = $clog2(PULSE_CYCLES + 1);
    localparam int SW = $clog2(SEC_CYCLES + 1);

    // all module state
    typedef struct packed {
        ctts_ctrl_t  ctrl;
        logic        en_prev;
        logic        cycle_active;
        logic        low_passed;
        logic        timer_fault;
        logic        half_phase;
        logic [15:0] elapsed;
        logic [SW-1:0] presc;
        logic [PW-1:0] pulse_cnt;
        ctts_dpm_t   dpm;
        logic        boost_susp;
        logic        batsw_on;
        logic        suppl;
        logic [1:0]  isel;
        logic        v4v1;
        logic        charging;
        logic        boost_en;
        logic        irq_n;
        logic [31:0] rdata;
    } ctts_state_t;

    ctts_state_t st_reg;
    ctts_state_t st_next;

    // zone from the comparators: cold and hot checked first, then cool and warm
    function automatic ctts_zone_t zone_of(input ctts_ts_t c);
        if (c.above_t1) begin
            return ZONE_COLD;
        end else if (c.below_t4) begin
            return ZONE_HOT;
        end else if (c.above_t2) begin
            return ZONE_COOL;
        end else if (c.below_t3) begin
            return ZONE_WARM;
        end
        return ZONE_NORMAL;
    endfunction : zone_of

    ctts_zone_t   zone;
    logic         in_window;
    logic         boost_out;
    logic [2:0]   ntc_code;
    logic         chg_en;
    logic         en_toggle;
    logic         timer_clear;
    logic         sec_tick;
    logic         slow;
    logic         step;
    logic [15:0]  limit;
    logic         expire;
    logic         irq_fire;
    ctts_status_t status;

    // zone and window decode
    always_comb begin
        zone      = zone_of(ts_cmp_i);
        in_window = (zone != ZONE_COLD) && (zone != ZONE_HOT);
        boost_out = ts_cmp_i.above_bcold || ts_cmp_i.below_bhot;
        chg_en    = st_reg.ctrl.charge_config_bit && !charge_enable_pin_n_i;
        en_toggle = chg_en != st_reg.en_prev;
        timer_clear = restart_i || en_toggle;
    end

    // thermistor fault code: boost codes in boost, zone codes otherwise
    always_comb begin
        ntc_code = NTC_NORMAL;
        if (boost_request_i) begin
            if (ts_cmp_i.above_bcold) begin
                ntc_code = NTC_COLD;
            end else if (ts_cmp_i.below_bhot) begin
                ntc_code = NTC_HOT;
            end
        end else begin
            unique case (zone)
                ZONE_COLD:   ntc_code = NTC_COLD;
                ZONE_HOT:    ntc_code = NTC_HOT;
                ZONE_COOL:   ntc_code = NTC_COOL;
                ZONE_WARM:   ntc_code = NTC_WARM;
                ZONE_NORMAL: ntc_code = NTC_NORMAL;
                default:     ntc_code = NTC_NORMAL;
            endcase
        end
    end

    // safety timer rate, step and limit
    always_comb begin
        sec_tick = st_reg.presc == SW'(SEC_CYCLES - 1);
        slow = st_reg.ctrl.double_time_enable
               && (vin_limit_i || iin_limit_i || thermal_reg_i
                   || zone == ZONE_COOL);
        step = sec_tick && (!slow || st_reg.half_phase);
        if (!st_reg.low_passed) begin
            limit = LIM_SHORT_S;
        end else if (st_reg.ctrl.safety_timer_length) begin
            limit = LIM_LONG_S;
        end else begin
            limit = LIM_HALF_S;
        end
        expire = st_reg.ctrl.timer_enable && st_reg.cycle_active
                 && !st_reg.timer_fault && (st_reg.elapsed >= limit);
        irq_fire = expire || (boost_request_i && (boost_out != st_reg.boost_susp));
    end

    // status word
    always_comb begin
        status = '0;
        status.bus_source_status = st_reg.boost_susp ? BUS_STAT_NONE : bus_source_i;
        status.thermistor_fault_code    = ntc_code;
        status.charge_fault_code        = st_reg.timer_fault ? CHG_FLT_TIMER : CHG_FLT_NONE;
        status.min_system_reg_flag      = sys_at_min_i;
        status.input_current_limit_flag = st_reg.dpm == DPM_IIN;
        status.input_voltage_limit_flag = st_reg.dpm == DPM_VIN;
        status.zone                     = zone;
        status.charging                 = st_reg.charging;
        status.supplement               = st_reg.suppl;
        status.battery_switch           = st_reg.batsw_on;
    end

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.rdata   = '0;
        st_next.en_prev = chg_en;

        // register writes
        if (we_i && addr_i == ADDR_CTRL) begin
            st_next.ctrl = ctts_ctrl_t'(wdata_i[$bits(ctts_ctrl_t)-1:0]);
        end
        // register reads: data stands for the next cycle only
        if (re_i) begin
            unique case (addr_i)
                ADDR_CTRL:   st_next.rdata = 32'(st_reg.ctrl);
                ADDR_STATUS: st_next.rdata = 32'(status);
                ADDR_TIMER:  st_next.rdata = 32'(st_reg.elapsed);
                default:     st_next.rdata = '0;
            endcase
        end

        // charge cycle start and stop
        if (!chg_en || restart_i) begin
            st_next.cycle_active = 1'b0;
        end else if (!st_reg.cycle_active && charge_request_i && in_window
                     && !st_reg.timer_fault) begin
            st_next.cycle_active = 1'b1;
        end

        // safety timer prescaler and count
        st_next.presc = sec_tick ? '0 : SW'(st_reg.presc + 1'b1);
        if (timer_clear) begin
            st_next.elapsed     = '0;
            st_next.half_phase  = 1'b0;
            st_next.low_passed  = 1'b0;
            st_next.timer_fault = expire; // expiry wins
        end else begin
            if (sec_tick) begin
                st_next.half_phase = !st_reg.half_phase;
            end
            if (batt_above_low_i && st_reg.cycle_active) begin
                st_next.low_passed = 1'b1;
            end
            if (!st_reg.ctrl.timer_enable) begin
                st_next.elapsed = '0;
            end else if (step && st_reg.cycle_active && in_window
                         && !fault_suspend_i && !st_reg.timer_fault
                         && st_reg.elapsed != '1) begin
                st_next.elapsed = st_reg.elapsed + 16'h0001;
            end
            if (expire) begin
                st_next.timer_fault = 1'b1;
            end
        end

        // charge outputs and zone limits
        st_next.charging = st_reg.cycle_active && in_window
                           && !st_reg.timer_fault && !expire && !fault_suspend_i;
        st_next.v4v1 = 1'b0;
        st_next.isel = ISEL_FULL;
        if (!st_next.charging) begin
            st_next.isel = ISEL_ZERO;
        end else if (st_reg.ctrl.zone_limit_enable) begin
            if (zone == ZONE_WARM) begin
                st_next.v4v1 = st_reg.ctrl.warm_voltage_select;
            end
            if (zone == ZONE_COOL) begin
                st_next.isel = st_reg.ctrl.cool_current_select ? ISEL_FIFTH : ISEL_HALF;
            end
        end

        // input limiting type latched on first limit reached
        if (!iin_limit_i && !vin_limit_i) begin
            st_next.dpm = DPM_NONE;
        end else if (st_reg.dpm == DPM_NONE) begin
            st_next.dpm = iin_limit_i ? DPM_IIN : DPM_VIN;
        end else if (st_reg.dpm == DPM_IIN && !iin_limit_i) begin
            st_next.dpm = DPM_VIN;
        end else if (st_reg.dpm == DPM_VIN && !vin_limit_i) begin
            st_next.dpm = DPM_IIN;
        end

        // boost temperature supervision
        st_next.boost_susp = boost_request_i && boost_out;
        st_next.boost_en   = boost_request_i && !boost_out;

        // battery switch and supplement mode
        if (batt_depleted_i && (st_reg.suppl || supplement_req_i)) begin
            st_next.batsw_on = 1'b0;
            st_next.suppl    = 1'b0;
        end else begin
            st_next.batsw_on = 1'b1;
            st_next.suppl    = supplement_req_i && !batt_depleted_i;
        end

        // interrupt pulse, one low pulse per event seen while the line is high
        if (irq_fire && st_reg.pulse_cnt == '0) begin
            st_next.pulse_cnt = PW'(PULSE_CYCLES);
        end else if (st_reg.pulse_cnt != '0) begin
            st_next.pulse_cnt = st_reg.pulse_cnt - 1'b1;
        end
        st_next.irq_n = st_next.pulse_cnt == '0;
    end

    // state register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg              <= '0;
            st_reg.ctrl         <= CTRL_RST;
            st_reg.en_prev      <= 1'b1;
            st_reg.dpm          <= DPM_NONE;
            st_reg.batsw_on     <= 1'b1;
            st_reg.isel         <= ISEL_ZERO;
            st_reg.irq_n        <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign rdata_o                      = st_reg.rdata;
    assign charging_o                   = st_reg.charging;
    assign current_select_o             = st_reg.isel;
    assign voltage_limit_4v1_o          = st_reg.v4v1;
    assign dpm_reduce_o                 = st_reg.dpm != DPM_NONE;
    assign boost_enable_o               = st_reg.boost_en;
    assign battery_switch_on_o          = st_reg.batsw_on;
    assign supplement_o                 = st_reg.suppl;
    assign min_system_voltage_setting_o = st_reg.ctrl.min_system_voltage_setting;
    assign interrupt_pulse_n_o          = st_reg.irq_n;

endmodule : ctts_supervisor

// *** inc/ctts_pkg.sv ***
// package of constants and types for the charge thermal and timer supervisor
package ctts_pkg;

    // clock and timing figures
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
    localparam int unsigned IRQ_PULSE_US  = 256;
    localparam int unsigned IRQ_PULSE_CYC = IRQ_PULSE_US * CLK_PER_US;
    localparam int unsigned SEC_CYC       = CLK_HZ;
    localparam int unsigned SEC_PER_HOUR  = 3600;
    localparam int unsigned LIM_SHORT_H   = 2;
    localparam int unsigned LIM_LONG_H    = 10;
    localparam int unsigned LIM_HALF_H    = 5;
    localparam logic [15:0] LIM_SHORT_S   = 16'(LIM_SHORT_H * SEC_PER_HOUR);
    localparam logic [15:0] LIM_LONG_S    = 16'(LIM_LONG_H * SEC_PER_HOUR);
    localparam logic [15:0] LIM_HALF_S    = 16'(LIM_HALF_H * SEC_PER_HOUR);

    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TIMER  = 8'h08;

    // field codes
    localparam logic [2:0] SYS_MIN_RST   = 3'h5; // setting for 3.5 v
    localparam logic [2:0] BUS_STAT_NONE = 3'h0;
    localparam logic [2:0] NTC_NORMAL    = 3'h0;
    localparam logic [2:0] NTC_WARM      = 3'h2;
    localparam logic [2:0] NTC_COOL      = 3'h3;
    localparam logic [2:0] NTC_COLD      = 3'h5;
    localparam logic [2:0] NTC_HOT       = 3'h6;
    localparam logic [1:0] CHG_FLT_NONE  = 2'h0;
    localparam logic [1:0] CHG_FLT_TIMER = 2'h3;

    // charge current target select
    localparam logic [1:0] ISEL_FULL = 2'h0;
    localparam logic [1:0] ISEL_HALF = 2'h1;
    localparam logic [1:0] ISEL_FIFTH = 2'h2;
    localparam logic [1:0] ISEL_ZERO = 2'h3;

    typedef enum logic [2:0] {
        ZONE_NORMAL = 3'b000,
        ZONE_COOL   = 3'b001,
        ZONE_WARM   = 3'b010,
        ZONE_COLD   = 3'b011,
        ZONE_HOT    = 3'b100
    } ctts_zone_t;

    typedef enum logic [1:0] {
        DPM_NONE = 2'b00,
        DPM_IIN  = 2'b01,
        DPM_VIN  = 2'b10
    } ctts_dpm_t;

    // thermistor comparator outputs; lower sense voltage means hotter
    typedef struct packed {
        logic above_t1;    // colder than t1
        logic above_t2;    // colder than t2
        logic below_t3;    // hotter than t3
        logic below_t4;    // hotter than t4
        logic above_bcold; // colder than boost cold limit
        logic below_bhot;  // hotter than boost hot limit
    } ctts_ts_t;

    // software control register
    typedef struct packed {
        logic [2:0] min_system_voltage_setting;
        logic       zone_limit_enable;
        logic       cool_current_select;
        logic       warm_voltage_select;
        logic       double_time_enable;
        logic       safety_timer_length;
        logic       timer_enable;
        logic       charge_config_bit;
    } ctts_ctrl_t;

    localparam ctts_ctrl_t CTRL_RST = '{
        min_system_voltage_setting: SYS_MIN_RST,
        zone_limit_enable:          1'b1,
        cool_current_select:        1'b0,
        warm_voltage_select:        1'b0,
        double_time_enable:         1'b1,
        safety_timer_length:        1'b1,
        timer_enable:               1'b1,
        charge_config_bit:          1'b1
    };

    // read-only status register layout
    typedef struct packed {
        logic       battery_switch;
        logic       supplement;
        logic       charging;
        ctts_zone_t zone;
        logic       input_voltage_limit_flag;
        logic       input_current_limit_flag;
        logic       min_system_reg_flag;
        logic [1:0] charge_fault_code;
        logic [2:0] thermistor_fault_code;
        logic [2:0] bus_source_status;
    } ctts_status_t;

endpackage : ctts_pkg

// *** sim/ctts_therm_model.sv ***
// thermistor model: battery temperature zone to comparator levels
`timescale 1ns/1ps

module ctts_therm_model
    import ctts_pkg::*;
(
    input  wire ctts_zone_t zone_i,
    input  wire logic [1:0] boost_win_i,
    output ctts_ts_t        ts_cmp_o
);
    // colder battery keeps the sense voltage above more thresholds
    always_comb begin
        ts_cmp_o.above_t1    = (zone_i == ZONE_COLD);
        ts_cmp_o.above_t2    = (zone_i == ZONE_COLD) || (zone_i == ZONE_COOL);
        ts_cmp_o.below_t3    = (zone_i == ZONE_WARM) || (zone_i == ZONE_HOT);
        ts_cmp_o.below_t4    = (zone_i == ZONE_HOT);
        ts_cmp_o.above_bcold = boost_win_i[1];
        ts_cmp_o.below_bhot  = boost_win_i[0];
    end
endmodule : ctts_therm_model

// *** sim/ctts_supervisor_properties.sv ***
// port checks for the charge thermal and timer supervisor
`timescale 1ns/1ps

module ctts_supervisor_properties
    import ctts_pkg::*;
#(
    parameter int unsigned SEC_CYCLES   = SEC_CYC,
    parameter int unsigned PULSE_CYCLES = IRQ_PULSE_CYC
) (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        we_i,
    input wire logic        re_i,
    input wire logic [31:0] rdata_o,
    input wire ctts_ts_t    ts_cmp_i,
    input wire logic        iin_limit_i,
    input wire logic        vin_limit_i,
    input wire logic        boost_request_i,
    input wire logic        batt_depleted_i,
    input wire logic        charging_o,
    input wire logic        dpm_reduce_o,
    input wire logic        boost_enable_o,
    input wire logic        battery_switch_on_o,
    input wire logic        supplement_o,
    input wire logic [2:0]  min_system_voltage_setting_o,
    input wire logic        interrupt_pulse_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // length of the running low interrupt stretch
    logic [31:0] low_cnt_reg;
    logic [31:0] low_cnt_next;
    logic [2:0]  wsys;
    assign wsys = wdata_i[9:7];
    always_comb low_cnt_next = interrupt_pulse_n_o ? 32'h0 : low_cnt_reg + 32'h1;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) low_cnt_reg <= 32'h0;
        else low_cnt_reg <= low_cnt_next;
    end

    chk_window_stop: assert property (
        ts_cmp_i.above_t1 || ts_cmp_i.below_t4 |=> !charging_o)
        else $error("charging outside the temperature window");
    chk_irq_width: assert property (
        $rose(interrupt_pulse_n_o) |-> low_cnt_reg == PULSE_CYCLES)
        else $error("interrupt pulse of wrong length");
    chk_irq_bounded: assert property (
        !interrupt_pulse_n_o |-> low_cnt_reg < PULSE_CYCLES)
        else $error("interrupt held low too long");
    chk_dpm_follow: assert property (
        1'b1 |=> dpm_reduce_o == ($past(iin_limit_i) || $past(vin_limit_i)))
        else $error("current cut does not follow input limiting");
    chk_sysmin_write: assert property (
        (we_i && addr_i == ADDR_CTRL) ##1 !(we_i && addr_i == ADDR_CTRL)
        |=> min_system_voltage_setting_o == $past(wsys, 2))
        else $error("minimum system setting not taken from write");
    chk_read_idle: assert property (
        !re_i |=> rdata_o == 32'h0)
        else $error("read data not zero without a read");
    chk_boost_suspend: assert property (
        !boost_request_i || ts_cmp_i.above_bcold || ts_cmp_i.below_bhot
        |=> !boost_enable_o)
        else $error("boost running outside its window");
    chk_depleted_off: assert property (
        batt_depleted_i |=> !battery_switch_on_o && !supplement_o)
        else $error("battery switch on while depleted");

    cover property ($fell(interrupt_pulse_n_o));
    cover property (boost_request_i && ts_cmp_i.above_bcold);
    cover property (iin_limit_i && vin_limit_i);
endmodule : ctts_supervisor_properties

bind ctts_supervisor ctts_supervisor_properties #(
    .SEC_CYCLES  (SEC_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)
) u_props (.clk_i, .arst_n_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .ts_cmp_i,
    .iin_limit_i, .vin_limit_i, .boost_request_i, .batt_depleted_i, .charging_o,
    .dpm_reduce_o, .boost_enable_o, .battery_switch_on_o, .supplement_o,
    .min_system_voltage_setting_o, .interrupt_pulse_n_o);

// *** sim/test_ctts_supervisor.sv ***
// self-checking testbench for the charge thermal and timer supervisor
`timescale 1ns/1ps

module test_ctts_supervisor;
    import ctts_pkg::*;
    localparam int SEC = 2;
    logic        clk_i, arst_n_i, we_i, re_i, restart_i, fault_suspend_i, thermal_reg_i;
    logic        charge_enable_pin_n_i, charge_request_i, batt_above_low_i, sys_at_min_i;
    logic        iin_limit_i, vin_limit_i, boost_request_i, supplement_req_i, batt_depleted_i;
    logic        charging_o, voltage_limit_4v1_o, dpm_reduce_o, boost_enable_o;
    logic        battery_switch_on_o, supplement_o, interrupt_pulse_n_o;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, st;
    logic [2:0]  bus_source_i, min_system_voltage_setting_o;
    logic [1:0]  current_select_o, bwin;
    ctts_ts_t    ts_cmp_i;
    ctts_zone_t  zone;
    ctts_ctrl_t  cr;
    int          err_count, n_compared;

    ctts_supervisor #(.SEC_CYCLES(SEC), .PULSE_CYCLES(8)) u_dut (.*);
    ctts_therm_model u_therm (.zone_i(zone), .boost_win_i(bwin), .ts_cmp_o(ts_cmp_i));

    // clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        we_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        re_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i   <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask : rd

    task automatic wc();
        wr(ADDR_CTRL, 32'(cr));
    endtask : wc

    // cycles until the interrupt line goes low, -1 if it never does
    task automatic wirq(input int lim, output int n);
        n = -1;
        for (int i = 0; i < lim && n < 0; i++) begin
            @(negedge clk_i);
            if (interrupt_pulse_n_o === 1'b0) n = i;
        end
    endtask : wirq

    task automatic rate(output int d);
        logic [31:0] a, b;
        rd(ADDR_TIMER, a);
        cyc(200);
        rd(ADDR_TIMER, b);
        d = int'(b - a);
    endtask : rate

    task automatic t_regs();
        logic [31:0] d;
        @(negedge clk_i);
        chk("minsys_rst", 32'(min_system_voltage_setting_o), 32'(SYS_MIN_RST));
        rd(ADDR_CTRL, d);
        chk("ctrl_rst", d, 32'h2cf);
        cr.min_system_voltage_setting = 3'h2;
        wc();
        wr(8'h3c, 32'h0);
        rd(ADDR_CTRL, d);
        chk("ctrl_keep", d, 32'(cr));
        chk("minsys_set", 32'(min_system_voltage_setting_o), 32'h2);
        rd(8'h3c, d);
        chk("unmapped", d, 32'h0);
        cr = CTRL_RST;
        wc();
    endtask : t_regs

    task automatic t_zones();
        ctts_zone_t zl[5] = '{ZONE_NORMAL, ZONE_COOL, ZONE_WARM, ZONE_COLD, ZONE_HOT};
        logic       out;
        logic [1:0] es;
        for (int p = 0; p < 3; p++) begin
            cr.cool_current_select = (p == 1);
            cr.warm_voltage_select = (p != 0);
            cr.zone_limit_enable   = (p != 2);
            wc();
            for (int i = 0; i < (p == 2 ? 3 : 5); i++) begin
                out = (i > 2);
                es = out ? ISEL_ZERO : (i != 1 || p == 2) ? ISEL_FULL
                   : (p == 1) ? ISEL_FIFTH : ISEL_HALF;
                zone <= zl[i];
                cyc(3);
                rd(ADDR_STATUS, st);
                chk("zone", 32'(st[13:11]), 32'(zl[i]));
                chk("charging", 32'(charging_o), 32'(!out));
                chk("cur_sel", 32'(current_select_o), 32'(es));
                chk("v4v1", 32'(voltage_limit_4v1_o), 32'(i == 2 && p == 1));
                cyc(1);
            end
        end
        zone <= ZONE_NORMAL;
        cr = CTRL_RST;
        wc();
    endtask : t_zones

    task automatic t_boost();
        int n;
        charge_request_i <= 1'b0;
        boost_request_i  <= 1'b1;
        cyc(3);
        for (int k = 0; k < 2; k++) begin
            bwin <= k ? 2'b01 : 2'b10;
            wirq(10, n);
            chk("boost_irq", 32'(n >= 0), 32'h1);
            cyc(12);
            rd(ADDR_STATUS, st);
            chk("boost_off", 32'(boost_enable_o), 32'h0);
            chk("bus_stat", 32'(st[2:0]), 32'(BUS_STAT_NONE));
            chk("ntc_code", 32'(st[5:3]), 32'(k ? NTC_HOT : NTC_COLD));
            cyc(1);
            bwin <= 2'b00;
            cyc(12);
            rd(ADDR_STATUS, st);
            chk("boost_on", 32'(boost_enable_o), 32'h1);
            chk("ntc_clear", 32'(st[5:3]), 32'(NTC_NORMAL));
            cyc(1);
        end
        boost_request_i  <= 1'b0;
        charge_request_i <= 1'b1;
    endtask : t_boost

    task automatic t_dpm();
        iin_limit_i <= 1'b1;
        cyc(3);
        rd(ADDR_STATUS, st);
        chk("dpm_iin", 32'(st[10:8]), 32'h2);
        cyc(1);
        vin_limit_i <= 1'b1;
        cyc(3);
        rd(ADDR_STATUS, st);
        chk("dpm_first", 32'(st[10:8]), 32'h2);
        chk("dpm_cut", 32'(dpm_reduce_o), 32'h1);
        cyc(1);
        iin_limit_i  <= 1'b0;
        sys_at_min_i <= 1'b1;
        cyc(3);
        rd(ADDR_STATUS, st);
        chk("dpm_vin", 32'(st[10:8]), 32'h5);
        cyc(1);
        {vin_limit_i, sys_at_min_i, supplement_req_i} <= 3'b001;
        cyc(3);
        @(negedge clk_i);
        chk("supp_on", 32'({battery_switch_on_o, supplement_o}), 32'h3);
        cyc(1);
        batt_depleted_i <= 1'b1;
        cyc(3);
        @(negedge clk_i);
        chk("depleted", 32'({battery_switch_on_o, supplement_o}), 32'h0);
        cyc(1);
        {batt_depleted_i, supplement_req_i} <= 2'b00;
    endtask : t_dpm

    task automatic t_timer();
        int          d;
        logic [31:0] h, t;
        charge_enable_pin_n_i <= 1'b1;
        cyc(3);
        charge_enable_pin_n_i <= 1'b0;
        cyc(3);
        rd(ADDR_TIMER, t);
        chk("tmr_clear", 32'(t < 5), 32'h1);
        rate(d);
        chk("full_rate", 32'(d >= 99 && d <= 103), 32'h1);
        cyc(1);
        iin_limit_i <= 1'b1;
        cyc(3);
        rate(d);
        chk("half_rate", 32'(d >= 48 && d <= 53), 32'h1);
        cyc(1);
        {iin_limit_i, thermal_reg_i} <= 2'b01;
        cyc(3);
        rate(d);
        chk("half_thermal", 32'(d >= 48 && d <= 53), 32'h1);
        cr.double_time_enable = 1'b0;
        wc();
        rate(d);
        chk("no_slow", 32'(d >= 99 && d <= 103), 32'h1);
        cyc(1);
        {iin_limit_i, thermal_reg_i, fault_suspend_i} <= 3'b001;
        cyc(3);
        rate(d);
        chk("paused", 32'(d), 32'h0);
        rd(ADDR_TIMER, h);
        cyc(1);
        fault_suspend_i <= 1'b0;
        cyc(6);
        rd(ADDR_TIMER, t);
        chk("resumed", 32'(t > h && t - h < 8), 32'h1);
        cr = CTRL_RST;
        cr.timer_enable = 1'b0;
        wc();
        cyc(3);
        rd(ADDR_TIMER, t);
        chk("tmr_off", t, 32'h0);
        cr = CTRL_RST;
    endtask : t_timer

    task automatic t_expire(input logic hi, input logic len, input int lim);
        int n;
        batt_above_low_i <= hi;
        cr.safety_timer_length = len;
        cr.charge_config_bit   = 1'b0;
        wc();
        cr.charge_config_bit = 1'b1;
        wc();
        wirq(lim * SEC + 100, n);
        chk("expiry", 32'(n >= lim * SEC - 10 && n <= lim * SEC + 10), 32'h1);
        rd(ADDR_STATUS, st);
        chk("chg_fault", 32'(st[7:6]), 32'(CHG_FLT_TIMER));
        chk("chg_stop", 32'(charging_o), 32'h0);
        cyc(1);
        restart_i <= 1'b1;
        cyc(1);
        restart_i <= 1'b0;
        cyc(3);
        rd(ADDR_STATUS, st);
        chk("restarted", 32'({st[7:6], charging_o}), 32'h1);
        cyc(1);
    endtask : t_expire

    // main sequence
    initial begin
        {we_i, re_i, restart_i, fault_suspend_i, iin_limit_i, vin_limit_i} = '0;
        {thermal_reg_i, sys_at_min_i, boost_request_i, supplement_req_i} = '0;
        {batt_depleted_i, charge_enable_pin_n_i, arst_n_i, batt_above_low_i} = '0;
        charge_request_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        bus_source_i = 3'h7;
        zone = ZONE_NORMAL;
        bwin = 2'b00;
        cr = CTRL_RST;
        err_count = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        cyc(2);
        t_regs();
        t_zones();
        t_boost();
        t_dpm();
        t_timer();
        t_expire(1'b0, 1'b1, int'(LIM_SHORT_S));
        t_expire(1'b1, 1'b0, int'(LIM_HALF_S));
        final_report();
    end

    // watchdog
    initial begin
        #400_000;
        err_count++;
        final_report();
    end
endmodule : test_ctts_supervisor
